//--- common/pmc_map.vh
/*
 * Register map and constants of the performance-monitor control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PMC_OFF_CTRL        12'h000
`define PMC_OFF_EVID_LO_L   12'h004
`define PMC_OFF_EVID_LO_H   12'h008
`define PMC_OFF_EVID_HI_L   12'h00C
`define PMC_OFF_EVID_HI_H   12'h010
`define PMC_OFF_CYC_L       12'h014
`define PMC_OFF_CYC_H       12'h018
`define PMC_OFF_ACCESS      12'h01C
`define PMC_OFF_STATUS      12'h020
`define PMC_OFF_EVCNT0      12'h024
`define PMC_OFF_EVCNT1      12'h028
`define PMC_OFF_EVCNT2      12'h02C
`define PMC_OFF_EVCNT3      12'h030
`define PMC_OFF_EVCNT4      12'h034
`define PMC_OFF_EVCNT5      12'h038

// ----------------------------------------------------------------------------
// Identification register values
// ----------------------------------------------------------------------------
`define PMC_EVID_LO         64'h0000_0000_0000_0F3F
`define PMC_EVID_HI         64'h0000_0000_00F2_A663

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define PMC_CTRL_IMP_HI     31
`define PMC_CTRL_IMP_LO     24
`define PMC_CTRL_PART_HI    23
`define PMC_CTRL_PART_LO    16
`define PMC_CTRL_NCNT_HI    15
`define PMC_CTRL_NCNT_LO    11
`define PMC_CTRL_LC         6
`define PMC_CTRL_DP         5
`define PMC_CTRL_X          4
`define PMC_CTRL_D          3
`define PMC_CTRL_C          2
`define PMC_CTRL_P          1
`define PMC_CTRL_E          0
`define PMC_NCNT            5'h06
`define PMC_NCNT_INT        6
`define PMC_CTRL_RST        7'h00

// Access register fields: level [1:0], partition [4:2]
`define PMC_ACC_LVL_HI      1
`define PMC_ACC_LVL_LO      0
`define PMC_ACC_HPMN_HI     4
`define PMC_ACC_HPMN_LO     2
`define PMC_ACC_RST         5'h06
`define PMC_LVL_EL0         2'h0
`define PMC_LVL_EL1         2'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMC_DIV_CYCLES      64
`define PMC_DIV_W           6

`endif

//--- rtl/pmc_evcnt.v
/*
 * One 32-bit event counter with enable, clear and overflow pulse.
 * Assumes a synchronous event input on pclk.
 */
`timescale 1ns/100ps
module pmc_evcnt (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        cnt_en,
    input  wire        event_in,
    input  wire        clr,
    output reg  [31:0] count_q,
    output reg         ovf_q
);
    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h0000_0000;
            ovf_q   <= 1'b0;
        end else if (ce) begin
            ovf_q <= 1'b0;
            if (clr) begin
                count_q <= 32'h0000_0000;
            end else if (cnt_en && event_in) begin
                count_q <= count_q + 32'h0000_0001;
                ovf_q   <= (count_q == 32'hFFFF_FFFF);
            end
        end
    end
endmodule // pmc_evcnt

//--- rtl/pmc_top.v
/*
 * Performance-monitor control block: identification registers, control
 * register, cycle counter with prescaler, six event counters, overflow
 * status and event export, reached over APB.
 * Assumes a single pclk domain; events and debug-permission inputs arrive
 * from pins and are synchronised here.
 */
//
// Overview of operation
// - Identification bits read 1 for implemented events, 0 otherwise; read-only.
// - Low identification register bits 13,12,7,6 read 0; 11-8,5-0 read 1.
// - High identification register sets bits 23-20,17,15,13,10,9,6,5,1,0; 63:24 zero.
// - Control bits 31:24 implementer, 23:16 part code, read-only.
// - Control bits 15:11 report six event counters.
// - Long-cycle bit picks cycle overflow at bit 31 or bit 63.
// - Prohibited-stop bit halts cycle counter while debug not permitted.
// - Export bit gates event export; resets to zero.
// - Export bit never touches the overflow interrupt output.
// - Divider bit makes cycle counter step once per 64 cycles.
// - Writing 1 to bit 2 clears cycle counter; reads zero.
// - Cycle counter clear leaves its overflow flag alone.
// - Writing 1 to bit 1 clears event counters only; reads zero.
// - Low-level clear spares hypervisor-reserved counters; high level clears all.
// - Event counter clear leaves overflow flags alone.
// - Enable bit 0 enables all counters; zero disables all but the hypervisor-reserved ones at low level.
// - Low-level enable bit does not govern hypervisor-reserved counters.
// - Reset returns enable to zero, stopping counters.
// - One control storage serves both software register views.
//
`timescale 1ns/100ps
`include "pmc_map.vh"
module pmc_top #(
    parameter [7:0] IMPL_CODE = 8'h5A,  // Arbitrary value
    parameter [7:0] PART_CODE = 8'hA5   // Arbitrary value
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [5:0]  event_in,
    input  wire        debug_permit,
    output reg  [5:0]  export_evt_q,
    output reg         monitor_irq_n
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [6:0]  ctrl_q;
    reg  [4:0]  access_q;
    reg  [63:0] cycle_counter;
    reg  [`PMC_DIV_W-1:0] div_q;
    reg  [6:0]  overflow_status;
    reg  [5:0]  evt_s1_q;
    reg  [5:0]  evt_s2_q;
    reg         dbg_s1_q;
    reg         dbg_s2_q;
    reg  [5:0]  clr_ev;
    reg  [5:0]  en_ev;
    reg  [31:0] rdata_d;
    reg         addr_ok;
    wire [5:0]  ovf_ev;
    wire [191:0] ev_counts;
    wire [63:0] evid_lo;
    wire [63:0] evid_hi;
    wire        wr_acc;
    wire        rd_setup;
    wire        ctrl_wr;
    wire        low_level;
    wire [2:0]  hpmn;
    wire        cyc_run;
    wire        cyc_tick;
    wire [63:0] cyc_next;
    wire        cyc_ovf;
    wire        full_lanes;
    integer     i;

    assign wr_acc     = psel && penable && pwrite && !pready;
    assign rd_setup   = psel && !penable;
    assign full_lanes = (pstrb == 4'hF);
    assign ctrl_wr    = wr_acc && (paddr == `PMC_OFF_CTRL) && full_lanes;
    assign low_level  = (access_q[`PMC_ACC_LVL_HI:`PMC_ACC_LVL_LO] == `PMC_LVL_EL0) ||
                        (access_q[`PMC_ACC_LVL_HI:`PMC_ACC_LVL_LO] == `PMC_LVL_EL1);
    assign hpmn       = access_q[`PMC_ACC_HPMN_HI:`PMC_ACC_HPMN_LO];
    assign evid_lo    = `PMC_EVID_LO;
    assign evid_hi    = `PMC_EVID_HI;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_s1_q <= 6'h00;
            evt_s2_q <= 6'h00;
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
        end else if (ce) begin
            evt_s1_q <= event_in;
            evt_s2_q <= evt_s1_q;
            dbg_s1_q <= debug_permit;
            dbg_s2_q <= dbg_s1_q;
        end
    end

    // ------------------------------------------------------------------------
    // Control and access registers
    // ------------------------------------------------------------------------
    // Single storage for both register views; C and P are never stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `PMC_CTRL_RST;
            access_q <= `PMC_ACC_RST;
        end else if (ce) begin
            if (ctrl_wr) begin
                ctrl_q[`PMC_CTRL_LC] <= pwdata[`PMC_CTRL_LC];
                ctrl_q[`PMC_CTRL_DP] <= pwdata[`PMC_CTRL_DP];
                ctrl_q[`PMC_CTRL_X]  <= pwdata[`PMC_CTRL_X];
                ctrl_q[`PMC_CTRL_D]  <= pwdata[`PMC_CTRL_D];
                ctrl_q[`PMC_CTRL_E]  <= pwdata[`PMC_CTRL_E];
            end
            if (wr_acc && (paddr == `PMC_OFF_ACCESS) && full_lanes) begin
                access_q <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Event counter enables and clears
    // ------------------------------------------------------------------------
    always @* begin
        for (i = 0; i < `PMC_NCNT_INT; i = i + 1) begin
            // Counters at or above the partition belong to the hypervisor
            if (low_level && (i >= hpmn)) begin
                en_ev[i]  = 1'b1;
                clr_ev[i] = 1'b0;
            end else begin
                en_ev[i]  = ctrl_q[`PMC_CTRL_E];
                clr_ev[i] = ctrl_wr && pwdata[`PMC_CTRL_P];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PMC_NCNT_INT; g = g + 1) begin : g_ev
            pmc_evcnt u_cnt (
                .pclk     (pclk),
                .presetn  (presetn),
                .ce       (ce),
                .cnt_en   (en_ev[g]),
                .event_in (evt_s2_q[g]),
                .clr      (clr_ev[g]),
                .count_q  (ev_counts[g*32 +: 32]),
                .ovf_q    (ovf_ev[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Cycle counter with prescaler
    // ------------------------------------------------------------------------
    assign cyc_run  = ctrl_q[`PMC_CTRL_E] &&
                      !(ctrl_q[`PMC_CTRL_DP] && !dbg_s2_q);
    assign cyc_tick = cyc_run &&
                      (!ctrl_q[`PMC_CTRL_D] ||
                       (div_q == `PMC_DIV_CYCLES - 1));
    assign cyc_next = cycle_counter + 64'h0000_0000_0000_0001;
    assign cyc_ovf  = cyc_tick && (ctrl_q[`PMC_CTRL_LC] ?
                      (cycle_counter[63] && !cyc_next[63]) :
                      (cycle_counter[31] && !cyc_next[31]));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_counter <= 64'h0000_0000_0000_0000;
            div_q         <= {`PMC_DIV_W{1'b0}};
        end else if (ce) begin
            if (cyc_run) begin
                div_q <= div_q + {{(`PMC_DIV_W-1){1'b0}}, 1'b1};
            end
            if (ctrl_wr && pwdata[`PMC_CTRL_C]) begin
                cycle_counter <= 64'h0000_0000_0000_0000;
                div_q         <= {`PMC_DIV_W{1'b0}};
            end else if (cyc_tick) begin
                cycle_counter <= cyc_next;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Overflow status, interrupt and export
    // ------------------------------------------------------------------------
    // Counter clears never touch these flags; set wins over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_status <= 7'h00;
            monitor_irq_n   <= 1'b1;
            export_evt_q    <= 6'h00;
        end else if (ce) begin
            if (wr_acc && (paddr == `PMC_OFF_STATUS) && full_lanes) begin
                overflow_status <= (overflow_status & ~pwdata[6:0]) |
                                   {cyc_ovf, ovf_ev};
            end else begin
                overflow_status <= overflow_status | {cyc_ovf, ovf_ev};
            end
            monitor_irq_n <= ~(|(overflow_status | {cyc_ovf, ovf_ev}));
            export_evt_q  <= ctrl_q[`PMC_CTRL_X] ? evt_s2_q : 6'h00;
        end
    end

    // ------------------------------------------------------------------------
    // APB read mux
    // ------------------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `PMC_OFF_CTRL: begin
                rdata_d[`PMC_CTRL_IMP_HI:`PMC_CTRL_IMP_LO]   = IMPL_CODE;
                rdata_d[`PMC_CTRL_PART_HI:`PMC_CTRL_PART_LO] = PART_CODE;
                rdata_d[`PMC_CTRL_NCNT_HI:`PMC_CTRL_NCNT_LO] = `PMC_NCNT;
                rdata_d[`PMC_CTRL_LC] = ctrl_q[`PMC_CTRL_LC];
                rdata_d[`PMC_CTRL_DP] = ctrl_q[`PMC_CTRL_DP];
                rdata_d[`PMC_CTRL_X]  = ctrl_q[`PMC_CTRL_X];
                rdata_d[`PMC_CTRL_D]  = ctrl_q[`PMC_CTRL_D];
                rdata_d[`PMC_CTRL_E]  = ctrl_q[`PMC_CTRL_E];  // C, P, 10:7 read 0
            end
            `PMC_OFF_EVID_LO_L: rdata_d = evid_lo[31:0];
            `PMC_OFF_EVID_LO_H: rdata_d = evid_lo[63:32];
            `PMC_OFF_EVID_HI_L: rdata_d = evid_hi[31:0];
            `PMC_OFF_EVID_HI_H: rdata_d = evid_hi[63:32];
            `PMC_OFF_CYC_L:     rdata_d = cycle_counter[31:0];
            `PMC_OFF_CYC_H:     rdata_d = cycle_counter[63:32];
            `PMC_OFF_ACCESS:    rdata_d[4:0] = access_q;
            `PMC_OFF_STATUS:    rdata_d[6:0] = overflow_status;
            `PMC_OFF_EVCNT0:    rdata_d = ev_counts[31:0];
            `PMC_OFF_EVCNT1:    rdata_d = ev_counts[63:32];
            `PMC_OFF_EVCNT2:    rdata_d = ev_counts[95:64];
            `PMC_OFF_EVCNT3:    rdata_d = ev_counts[127:96];
            `PMC_OFF_EVCNT4:    rdata_d = ev_counts[159:128];
            `PMC_OFF_EVCNT5:    rdata_d = ev_counts[191:160];
            default:            addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // APB response: one wait state, pready registered
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            if (rd_setup && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule // pmc_top

//--- sim/pmc_checker.sv
/* Port-level checker for pmc_top.
   Assumes one pclk domain and the APB map of pmc_map.vh. */
`timescale 1ns/100ps
module pmc_checker #(
    parameter [7:0] IMPL_CODE = 8'h5A,
    parameter [7:0] PART_CODE = 8'hA5
) (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [5:0]  event_in,
    input wire        debug_permit,
    input wire [5:0]  export_evt_q,
    input wire        monitor_irq_n
);
    reg  [6:0] ctrl_q;
    reg  [1:0] xoff_q;
    wire       acc = psel && penable && !pready && ce;
    wire       rd  = pready && !pwrite;
    // Mirror of the writable control bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 7'h00;
            xoff_q <= 2'd3;
        end else begin
            if (acc && pwrite && paddr == 12'h000 && pstrb == 4'hF) ctrl_q <= pwdata[6:0];
            xoff_q <= ctrl_q[4] ? 2'd0 : ((xoff_q == 2'd3) ? 2'd3 : xoff_q + 2'd1);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (acc |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_slverr_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h038))
        else $error("pslverr wrong");
    a_ctrl_fixed: assert property (rd && paddr == 12'h000 |->
        prdata[31:7] == {IMPL_CODE, PART_CODE, 5'h06, 4'h0}) else $error("control fixed fields wrong");
    a_ctrl_mirror: assert property (rd && paddr == 12'h000 |->
        prdata[6:0] == {ctrl_q[6:3], 2'b00, ctrl_q[0]}) else $error("control bits wrong");
    a_idlo_bits: assert property (rd && paddr == 12'h004 |-> (prdata & 32'h3FFF) == 32'h0F3F)
        else $error("low id wrong");
    a_idhi_bits: assert property (rd && paddr == 12'h00C |-> (prdata & 32'hFFF2A663) == 32'h00F2A663)
        else $error("high id wrong");
    a_idhi_upper: assert property (rd && paddr == 12'h010 |-> prdata == 32'h0)
        else $error("high id upper word wrong");
    a_export_off: assert property (xoff_q == 2'd3 |-> export_evt_q == 6'h00)
        else $error("export while disabled");
endmodule // pmc_checker
bind pmc_top pmc_checker #(.IMPL_CODE(IMPL_CODE), .PART_CODE(PART_CODE)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .debug_permit(debug_permit),
    .export_evt_q(export_evt_q), .monitor_irq_n(monitor_irq_n));

//--- sim/tb.sv
/* Self-checking bench for pmc_top over APB.
   Assumes pmc_map.vh on the include path. */
`timescale 1ns/100ps
`include "pmc_map.vh"
module tb;
    localparam [7:0] IMPL = 8'h5A;  // Arbitrary value
    localparam [7:0] PART = 8'hA5;  // Arbitrary value
    reg         pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, debug_permit = 1;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0;
    reg  [3:0]  pstrb = 0;
    reg  [5:0]  event_in = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, monitor_irq_n;
    wire [5:0]  export_evt_q;
    int         err_total = 0, comparisons = 0, cyc = 0, ts, t0, k;
    logic [31:0] r, a, ctrl_m;
    logic [5:0]  ev;
    logic        e;
    pmc_top #(.IMPL_CODE(IMPL), .PART_CODE(PART)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
        .debug_permit(debug_permit), .export_evt_q(export_evt_q), .monitor_irq_n(monitor_irq_n));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            err_total++;
            conclude();
        end
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        int n;
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        ts = cyc;
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: pready %h expected %h", $time, pready, 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic span(input logic [11:0] ad, input int w);
        apb(0, ad, 0, 0);
        a = r;
        t0 = ts;
        repeat (w) @(posedge pclk);
        apb(0, ad, 0, 0);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrc(input logic [31:0] d);
        apb(1, `PMC_OFF_CTRL, d, 4'hF);
        ctrl_m = d;
    endtask
    function automatic logic [31:0] cexp();
        return {IMPL, PART, 5'h06, 4'h0, ctrl_m[6:3], 2'b00, ctrl_m[0]};
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(79860));
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        ctrl_m = 0;
        apb(0, `PMC_OFF_CTRL, 0, 0); chk(r, cexp());
        apb(1, `PMC_OFF_EVID_LO_L, 32'hFFFFFFFF, 4'hF);
        apb(0, `PMC_OFF_EVID_LO_L, 0, 0); chk(r & 32'h3FFF, 32'h0F3F);
        apb(0, `PMC_OFF_EVID_HI_L, 0, 0); chk(r & 32'hFFF2A663, 32'h00F2A663);
        apb(0, `PMC_OFF_EVID_HI_H, 0, 0); chk(r, 0);
        apb(0, 12'h03C + 12'(($urandom % 16) * 4), 0, 0); chk({r[30:0], e}, 1);
        $display("test reset_and_id done");
        for (k = 0; k < 8; k++) begin
            wrc($urandom);
            apb(0, `PMC_OFF_CTRL, 0, 0); chk(r, cexp());
        end
        apb(1, `PMC_OFF_CTRL, ~ctrl_m, 4'h3);
        apb(0, `PMC_OFF_CTRL, 0, 0); chk(r, cexp());
        $display("test control_rw done");
        wrc(32'h5);
        apb(0, `PMC_OFF_CYC_L, 0, 0); chk({31'b0, r <= 8}, 1);
        a = r; t0 = ts;
        repeat (20) @(posedge pclk);
        apb(0, `PMC_OFF_CYC_L, 0, 0); chk(r - a, 32'(ts - t0));
        apb(0, `PMC_OFF_CYC_L, 0, 0);
        a = r;
        t0 = ts;
        ce <= 0;
        repeat (20) @(posedge pclk);
        ce <= 1;
        apb(0, `PMC_OFF_CYC_L, 0, 0);
        chk(r - a, 32'(ts - t0 - 20));
        debug_permit <= 0;
        for (k = 0; k < 3; k++) begin
            wrc(k == 0 ? 32'h0 : (k == 1 ? 32'h21 : 32'h1));
            repeat (4) @(posedge pclk);
            apb(0, `PMC_OFF_CYC_L, 0, 0); a = r; t0 = ts;
            repeat (30) @(posedge pclk);
            apb(0, `PMC_OFF_CYC_L, 0, 0); chk(r - a, k == 2 ? 32'(ts - t0) : 0);
        end
        debug_permit <= 1;
        wrc(32'hD);
        t0 = ts;
        repeat (600) @(posedge pclk);
        apb(0, `PMC_OFF_CYC_L, 0, 0);
        chk(r, 32'((ts - t0 - 2) / 64));
        $display("test cycle_counter done");
        event_in <= 6'h3F;
        wrc(32'h2);
        span(`PMC_OFF_EVCNT0, 10);
        chk(r, 0);
        apb(1, `PMC_OFF_ACCESS, 32'h0C, 4'hF);
        span(`PMC_OFF_EVCNT4, 10);
        chk(r - a, 32'(ts - t0));
        wrc(32'h2);
        apb(0, `PMC_OFF_EVCNT4, 0, 0);
        chk(r - a, 32'(ts - t0));
        apb(0, `PMC_OFF_EVCNT0, 0, 0);
        chk(r, 0);
        wrc(32'h1);
        span(`PMC_OFF_EVCNT1, 10);
        chk(r - a, 32'(ts - t0));
        wrc(32'h3);
        t0 = ts;
        apb(0, `PMC_OFF_EVCNT1, 0, 0);
        chk(r, 32'(ts - t0 - 2));
        apb(1, `PMC_OFF_ACCESS, 32'h06, 4'hF);
        wrc(32'h2);
        span(`PMC_OFF_EVCNT4, 10);
        chk(a, 0);
        chk(r, 0);
        event_in <= 6'h00;
        $display("test event_counters done");
        for (k = 0; k < 6; k++) begin
            wrc(k[0] ? 32'h10 : 32'h0);
            ev = $urandom;
            event_in <= ev;
            repeat (6) @(posedge pclk);
            chk(32'(export_evt_q), k[0] ? 32'(ev) : 0);
            chk({31'b0, monitor_irq_n}, 1);
        end
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        ctrl_m = 0;
        apb(0, `PMC_OFF_CTRL, 0, 0); chk(r, cexp());
        chk(32'(export_evt_q), 0);
        $display("test export_and_reset done");
        conclude();
    end
endmodule // tb
